//--- verilog/nco_pkg.sv
// Function
// - oscillator advances phase by 32-bit word
// - mixer multiplies real samples by exponential
// - four oscillators per channel, own settings
// - all accumulators run every cycle
// - pin change switches to indicated oscillator
// - select about 36-40, samples 36 cycles
// - source bit picks pins or field
// - select value is binary oscillator index
// - per-index frequency and phase settings
// - zero divider means plain binary mode
// - frequency change needs oscillator resync
// - nonzero divider gives exact rational steps
// - software keeps divider an integer
// - software computes rational frequency word
// - divider above 8192 not advised
// - phase offset left-justified then added
package nco_pkg;
  // ------------------------------------------------------------
  // widths and counts
  // ------------------------------------------------------------
  localparam int NUM_CHAN    = 2;
  localparam int NUM_OSC     = 4;
  localparam int FREQ_W      = 32;
  localparam int PHASE_W     = 16;
  localparam int SAMP_W      = 12;
  localparam int MIX_W       = 16;
  localparam int RDIV_W      = 16;
  localparam int RAT_SHIFT   = 6;    // divider counts in units of 64 clocks
  localparam int SYNC_STAGES = 3;
  localparam int SAMPLE_LAT  = 36;   // sample to mixer output, cycles
  localparam int SEL_LAT     = 36;   // synchronised pin to mixer, cycles
  localparam int FIFO_DEPTH  = 16;
  localparam int FIFO_WIDTH  = 4 * MIX_W;
  localparam logic [RDIV_W-1:0] RDIV_ADVISED_MAX = 16'h2000;

  // ------------------------------------------------------------
  // register map of the controller
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_RDIV    = 8'h08;
  localparam logic [7:0] ADDR_PINS    = 8'h0C;
  localparam logic [7:0] ADDR_DATA_A  = 8'h10;
  localparam logic [7:0] ADDR_DATA_B  = 8'h14;
  localparam logic [3:0] REG_FREQ_A   = 4'h2;
  localparam logic [3:0] REG_FREQ_B   = 4'h3;
  localparam logic [3:0] REG_PHASE_A  = 4'h4;
  localparam logic [3:0] REG_PHASE_B  = 4'h5;
  localparam int CTRL_SRC     = 0;
  localparam int CTRL_SELA    = 1;
  localparam int CTRL_SELB    = 3;
  localparam int CTRL_RESYNC  = 5;
  localparam int CTRL_OVR_CLR = 6;
  localparam int ST_EMPTY     = 0;
  localparam int ST_FULL      = 1;
  localparam int ST_OVERRUN   = 2;
  localparam int ST_RDIV_HIGH = 3;
  localparam int PINS_B       = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ------------------------------------------------------------
  // sine lookup, 64 points per turn, amplitude 2047
  // ------------------------------------------------------------
  function automatic logic [11:0] quarter(input logic [3:0] i);
    unique case (i)
      4'h0: quarter = 12'h064;
      4'h1: quarter = 12'h12C;
      4'h2: quarter = 12'h1F1;
      4'h3: quarter = 12'h2B2;
      4'h4: quarter = 12'h36B;
      4'h5: quarter = 12'h41C;
      4'h6: quarter = 12'h4C3;
      4'h7: quarter = 12'h55F;
      4'h8: quarter = 12'h5ED;
      4'h9: quarter = 12'h66C;
      4'hA: quarter = 12'h6DC;
      4'hB: quarter = 12'h73A;
      4'hC: quarter = 12'h787;
      4'hD: quarter = 12'h7C2;
      4'hE: quarter = 12'h7E9;
      4'hF: quarter = 12'h7FD;
    endcase
  endfunction

  function automatic logic signed [11:0] sine6(input logic [5:0] ph);
    logic [11:0] m;
    m = quarter(ph[4] ? ~ph[3:0] : ph[3:0]);
    sine6 = ph[5] ? -signed'(m) : signed'(m);
  endfunction
endpackage

//--- verilog/nco_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nco_link_if;
  // settings from the controller
  logic [3:0][31:0] freq_word_chan_a;
  logic [3:0][31:0] freq_word_chan_b;
  logic [3:0][15:0] phase_offset_chan_a;
  logic [3:0][15:0] phase_offset_chan_b;
  logic [15:0]      rational_divider;
  logic             select_source_ctrl;
  logic [1:0]       osc_select_field_chan_a;
  logic [1:0]       osc_select_field_chan_b;
  logic [1:0]       osc_select_pins_chan_a;
  logic [1:0]       osc_select_pins_chan_b;
  logic             resync;
  logic             overrun_clr;
  // mixed stream to the controller
  logic             mix_valid;
  logic             mix_ready;
  logic [15:0]      mix_i_a;
  logic [15:0]      mix_q_a;
  logic [15:0]      mix_i_b;
  logic [15:0]      mix_q_b;
  logic             overrun;

  modport dev (
    input  freq_word_chan_a, freq_word_chan_b, phase_offset_chan_a,
    input  phase_offset_chan_b, rational_divider, select_source_ctrl,
    input  osc_select_field_chan_a, osc_select_field_chan_b,
    input  osc_select_pins_chan_a, osc_select_pins_chan_b,
    input  resync, overrun_clr, mix_ready,
    output mix_valid, mix_i_a, mix_q_a, mix_i_b, mix_q_b, overrun
  );
  modport host (
    output freq_word_chan_a, freq_word_chan_b, phase_offset_chan_a,
    output phase_offset_chan_b, rational_divider, select_source_ctrl,
    output osc_select_field_chan_a, osc_select_field_chan_b,
    output osc_select_pins_chan_a, osc_select_pins_chan_b,
    output resync, overrun_clr, mix_ready,
    input  mix_valid, mix_i_a, mix_q_a, mix_i_b, mix_q_b, overrun
  );
endinterface
`default_nettype wire

//--- verilog/nco_mixer_dev.sv
`timescale 1ns/1ps
`default_nettype none
module nco_mixer_dev #(
  parameter int SAMPLE_LAT = nco_pkg::SAMPLE_LAT,
  parameter int SEL_LAT    = nco_pkg::SEL_LAT
) (
  // clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // link to the controlling end
  nco_link_if.dev                         link,
  // converter samples, taken when valid
  input  wire logic [nco_pkg::SAMP_W-1:0] adc_sample_chan_a,
  input  wire logic [nco_pkg::SAMP_W-1:0] adc_sample_chan_b,
  input  wire logic                       adc_valid
);
  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NCH     = nco_pkg::NUM_CHAN;
  localparam int NOSC    = nco_pkg::NUM_OSC;
  localparam int FW      = nco_pkg::FREQ_W;
  localparam int PW      = nco_pkg::PHASE_W;
  localparam int SW      = nco_pkg::SAMP_W;
  localparam int MW      = nco_pkg::MIX_W;
  localparam int NSYNC   = nco_pkg::SYNC_STAGES;
  localparam int SMP_DLY = SAMPLE_LAT - 1;
  localparam int SEL_DLY = SEL_LAT - NSYNC;
  localparam int CNT_W   = nco_pkg::RDIV_W + nco_pkg::RAT_SHIFT;
  localparam int PROD_W  = 2 * SW;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NCH-1:0][NOSC-1:0][FW-1:0]  acc;
    logic [CNT_W-1:0]                  rat_cnt;
    logic [NCH-1:0][NSYNC-1:0][1:0]    pin_sync;
    logic [NCH-1:0][SEL_DLY-1:0][1:0]  sel_dly;
    logic [SMP_DLY-1:0]                vld_dly;
    logic [NCH-1:0][SMP_DLY-1:0][SW-1:0] smp_dly;
    logic                              mix_valid;
    logic [NCH-1:0][MW-1:0]            mix_i;
    logic [NCH-1:0][MW-1:0]            mix_q;
    logic                              overrun;
  } state_t;

  state_t q;
  state_t d;

  // ------------------------------------------------------------
  // per-channel views of the link
  // ------------------------------------------------------------
  logic [NCH-1:0][NOSC-1:0][FW-1:0] freq;
  logic [NCH-1:0][NOSC-1:0][PW-1:0] phs;
  logic [NCH-1:0][1:0]              field;
  logic [NCH-1:0][1:0]              pins;
  logic [NCH-1:0][SW-1:0]           smp_in;
  logic                             rational;
  logic                             wrap;
  logic                             restart;
  logic                             freeze;
  logic [CNT_W-1:0]                 wrap_at;

  // each channel keeps its own four words and offsets
  assign freq[0]   = link.freq_word_chan_a;
  assign freq[1]   = link.freq_word_chan_b;
  assign phs[0]    = link.phase_offset_chan_a;
  assign phs[1]    = link.phase_offset_chan_b;
  assign field[0]  = link.osc_select_field_chan_a;
  assign field[1]  = link.osc_select_field_chan_b;
  assign pins[0]   = link.osc_select_pins_chan_a;
  assign pins[1]   = link.osc_select_pins_chan_b;
  assign smp_in[0] = adc_sample_chan_a;
  assign smp_in[1] = adc_sample_chan_b;

  // rational mode period: 64 * divider cycles, after which the exact
  // phase is a whole number of turns
  assign rational = link.rational_divider != '0;
  assign wrap_at  = {link.rational_divider, 6'h00} - CNT_W'(1);
  assign wrap     = rational && (q.rat_cnt == wrap_at);
  // a resync from the controller zeroes every accumulator
  assign restart  = link.resync || wrap;
  // held output that the far end has not taken stalls the sample path
  assign freeze   = q.mix_valid && !link.mix_ready;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [FW-1:0]            ph;
    logic [1:0]               sel;
    logic [SW-1:0]            x;
    logic signed [SW-1:0]     sn;
    logic signed [SW-1:0]     cs;
    logic signed [PROD_W-1:0] pi;
    logic signed [PROD_W-1:0] pq;
    ph = '0;
    sel = '0;
    x = '0;
    sn = '0;
    cs = '0;
    pi = '0;
    pq = '0;
    d = q;

    // step counter of rational mode, idle at zero in basic mode
    if (!rational || wrap) begin
      d.rat_cnt = '0;
    end else begin
      d.rat_cnt = q.rat_cnt + CNT_W'(1);
    end

    for (int c = 0; c < NCH; c++) begin
      // every accumulator runs, selected or not, so phase survives a hop
      for (int k = 0; k < NOSC; k++) begin
        if (restart) begin
          d.acc[c][k] = '0;
        end else begin
          d.acc[c][k] = q.acc[c][k] + freq[c][k];
        end
      end

      // pins are asynchronous; three flops before anyone reads them
      d.pin_sync[c] = {q.pin_sync[c][NSYNC-2:0], pins[c]};

      // choose the source of the index, the other one is ignored
      if (link.select_source_ctrl) begin
        sel = q.pin_sync[c][NSYNC-1];
      end else begin
        sel = field[c];
      end
      // index travels with the sample latency to reach the mixer
      d.sel_dly[c] = {q.sel_dly[c][SEL_DLY-2:0], sel};

      // binary index picks the oscillator seen by the mixer
      sel = q.sel_dly[c][SEL_DLY-1];
      ph  = q.acc[c][sel] + {phs[c][sel], 16'h0000};
      sn  = nco_pkg::sine6(ph[FW-1 -: 6]);
      cs  = nco_pkg::sine6(ph[FW-1 -: 6] + 6'h10);
      x   = q.smp_dly[c][SMP_DLY-1];
      // i = x*cos, q = -x*sin shifts the carrier by the oscillator
      pi  = signed'(x) * cs;
      pq  = -(signed'(x) * sn);

      if (!freeze) begin
        d.smp_dly[c] = {q.smp_dly[c][SMP_DLY-2:0], smp_in[c]};
        d.mix_i[c]   = pi[PROD_W-2 -: MW];
        d.mix_q[c]   = pq[PROD_W-2 -: MW];
      end
    end

    // sample valid moves unless a held output is not being taken
    if (!freeze) begin
      d.vld_dly   = {q.vld_dly[SMP_DLY-2:0], adc_valid};
      d.mix_valid = q.vld_dly[SMP_DLY-1];
    end

    // a sample offered while stalled is lost; flag it, set beats clear
    if (freeze && adc_valid) begin
      d.overrun = 1'b1;
    end else if (link.overrun_clr) begin
      d.overrun = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flops
  assign link.mix_valid = q.mix_valid;
  assign link.mix_i_a   = q.mix_i[0];
  assign link.mix_q_a   = q.mix_q[0];
  assign link.mix_i_b   = q.mix_i[1];
  assign link.mix_q_b   = q.mix_q[1];
  assign link.overrun   = q.overrun;
endmodule // nco_mixer_dev
`default_nettype wire

//--- verilog/nco_host_ctrl.sv
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module nco_sync_fifo #(
  parameter int WIDTH = nco_pkg::FIFO_WIDTH,
  parameter int DEPTH = nco_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [CW-1:0]               cnt;
    logic                        rdy;
  } fifo_t;

  fifo_t q;
  fifo_t d;
  logic  push;
  logic  pop;

  assign push = in_valid && q.rdy;
  assign pop  = out_ready && (q.cnt != '0);

  // pointers wrap explicitly so depth need not be a power of two
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
    end
    if (pop) begin
      d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + AW'(1);
    end
    d.cnt = q.cnt + CW'(push) - CW'(pop);
    d.rdy = d.cnt != CW'(DEPTH);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{default: '0, rdy: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign in_ready  = q.rdy;
  assign out_valid = q.cnt != '0;
  assign out_data  = q.mem[q.rp];
endmodule // nco_sync_fifo

module nco_host_ctrl (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // link to the oscillator end
  nco_link_if.host         link
);
  typedef struct packed {
    logic [3:0][31:0] freq_a;
    logic [3:0][31:0] freq_b;
    logic [3:0][15:0] phase_a;
    logic [3:0][15:0] phase_b;
    logic [15:0]      rdiv;
    logic             src;
    logic [1:0]       sel_a;
    logic [1:0]       sel_b;
    logic [3:0]       pins;
    logic             resync;
    logic             ovr_clr;
    logic             dph_wr;
    logic [7:0]       dph_addr;
    logic [31:0]      rdata;
  } host_t;

  host_t q;
  host_t d;
  logic  rd_req;
  logic  wr_req;
  logic  hit;
  logic  pop;
  logic  f_valid;
  logic  f_ready;
  logic [nco_pkg::FIFO_WIDTH-1:0] f_data;

  // only the low byte decodes; anything above it is unmapped
  function automatic logic [3:0] region(input logic [7:0] a);
    region = a[7:4];
  endfunction

  assign hit    = haddr[31:8] == '0;
  assign rd_req = hsel && hready && htrans[1] && !hwrite;
  assign wr_req = hsel && hready && htrans[1] && hwrite;
  // reading the second data word retires one fifo entry
  assign pop    = rd_req && hit && (haddr[7:0] == nco_pkg::ADDR_DATA_B);

  nco_sync_fifo #(
    .WIDTH (nco_pkg::FIFO_WIDTH),
    .DEPTH (nco_pkg::FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (link.mix_valid),
    .in_ready  (f_ready),
    .in_data   ({link.mix_i_a, link.mix_q_a, link.mix_i_b, link.mix_q_b}),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_data)
  );

  // ------------------------------------------------------------
  // register access: read data prepared in the address phase,
  // write data taken in the data phase; no wait states
  // ------------------------------------------------------------
  always_comb begin
    logic [1:0] ix;
    ix = haddr[3:2];
    d = q;
    d.resync  = 1'b0;
    d.ovr_clr = 1'b0;
    d.dph_wr  = wr_req && hit;
    d.dph_addr = haddr[7:0];
    d.rdata   = nco_pkg::RST_WORD;
    if (rd_req && hit) begin
      unique case (region(haddr[7:0]))
        nco_pkg::REG_FREQ_A:  d.rdata = q.freq_a[ix];
        nco_pkg::REG_FREQ_B:  d.rdata = q.freq_b[ix];
        nco_pkg::REG_PHASE_A: d.rdata = {16'h0000, q.phase_a[ix]};
        nco_pkg::REG_PHASE_B: d.rdata = {16'h0000, q.phase_b[ix]};
        default: begin
          unique case (haddr[7:0])
            nco_pkg::ADDR_CTRL:   d.rdata = {27'h0, q.sel_b, q.sel_a, q.src};
            nco_pkg::ADDR_RDIV:   d.rdata = {16'h0000, q.rdiv};
            nco_pkg::ADDR_PINS:   d.rdata = {28'h0, q.pins};
            nco_pkg::ADDR_DATA_A: d.rdata = f_valid ? f_data[63:32] : '0;
            nco_pkg::ADDR_DATA_B: d.rdata = f_valid ? f_data[31:0] : '0;
            nco_pkg::ADDR_STATUS: begin
              d.rdata[nco_pkg::ST_EMPTY]     = !f_valid;
              d.rdata[nco_pkg::ST_FULL]      = !f_ready;
              d.rdata[nco_pkg::ST_OVERRUN]   = link.overrun;
              // large dividers hurt spur level; flagged, still accepted
              d.rdata[nco_pkg::ST_RDIV_HIGH] = q.rdiv > nco_pkg::RDIV_ADVISED_MAX;
            end
            default: d.rdata = nco_pkg::RST_WORD;
          endcase
        end
      endcase
    end
    if (q.dph_wr) begin
      unique case (region(q.dph_addr))
        // frequency words are written as software computed them
        nco_pkg::REG_FREQ_A:  d.freq_a[q.dph_addr[3:2]] = hwdata;
        nco_pkg::REG_FREQ_B:  d.freq_b[q.dph_addr[3:2]] = hwdata;
        nco_pkg::REG_PHASE_A: d.phase_a[q.dph_addr[3:2]] = hwdata[15:0];
        nco_pkg::REG_PHASE_B: d.phase_b[q.dph_addr[3:2]] = hwdata[15:0];
        default: begin
          unique case (q.dph_addr)
            nco_pkg::ADDR_CTRL: begin
              d.src     = hwdata[nco_pkg::CTRL_SRC];
              d.sel_a   = hwdata[nco_pkg::CTRL_SELA +: 2];
              d.sel_b   = hwdata[nco_pkg::CTRL_SELB +: 2];
              d.resync  = hwdata[nco_pkg::CTRL_RESYNC];
              d.ovr_clr = hwdata[nco_pkg::CTRL_OVR_CLR];
            end
            nco_pkg::ADDR_RDIV: d.rdiv = hwdata[15:0];
            nco_pkg::ADDR_PINS: d.pins = hwdata[3:0];
            default: d.pins = q.pins;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = q.rdata;
  assign link.freq_word_chan_a        = q.freq_a;
  assign link.freq_word_chan_b        = q.freq_b;
  assign link.phase_offset_chan_a     = q.phase_a;
  assign link.phase_offset_chan_b     = q.phase_b;
  assign link.rational_divider        = q.rdiv;
  assign link.select_source_ctrl      = q.src;
  assign link.osc_select_field_chan_a = q.sel_a;
  assign link.osc_select_field_chan_b = q.sel_b;
  assign link.osc_select_pins_chan_a  = q.pins[1:0];
  assign link.osc_select_pins_chan_b  = q.pins[nco_pkg::PINS_B +: 2];
  assign link.resync                  = q.resync;
  assign link.overrun_clr             = q.ovr_clr;
  assign link.mix_ready               = f_ready;
endmodule // nco_host_ctrl
`default_nettype wire

//--- tb/nco_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module nco_link_asserts (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // mixed stream
  input wire logic        mix_valid,
  input wire logic        mix_ready,
  input wire logic [15:0] mix_i_a,
  input wire logic [15:0] mix_q_a,
  input wire logic [15:0] mix_i_b,
  input wire logic [15:0] mix_q_b,
  // pulses and status
  input wire logic        overrun,
  input wire logic        overrun_clr,
  input wire logic        resync
);
  // ----------
  // stream checks
  // ----------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a stalled entry must neither vanish nor change under the fifo
  sequence s_stall;
    mix_valid && !mix_ready;
  endsequence
  a_stall_hold: assert property (s_stall |=> mix_valid)
    else $error("stalled entry dropped");
  a_data_hold: assert property (s_stall |=> $stable({mix_i_a, mix_q_a, mix_i_b, mix_q_b}))
    else $error("stalled entry changed");
  // fifo may only fill shortly after a push
  a_ready_fall: assert property ($fell(mix_ready) |->
    $past(mix_valid && mix_ready) || $past(mix_valid && mix_ready, 2))
    else $error("ready fell without a push");
  // ----------
  // overrun and pulses
  // ----------
  // overrun is sticky, so a lost sample is never forgotten before software sees it
  a_ovr_sticky: assert property (overrun && !overrun_clr |=> overrun)
    else $error("overrun lost");
  a_ovr_clear: assert property (overrun_clr && mix_ready |=> !overrun)
    else $error("overrun not cleared");
  a_ovr_cause: assert property ($rose(overrun) |-> $past(!mix_ready))
    else $error("overrun without stall");
  a_sync_pulse: assert property (resync |=> !resync)
    else $error("resync longer than one cycle");
  a_clr_pulse: assert property (overrun_clr |=> !overrun_clr)
    else $error("clear longer than one cycle");
endmodule // nco_link_asserts
`default_nettype wire

//--- tb/quad_nco_complex_mixer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module quad_nco_complex_mixer_tb;
  // ----------
  // signals and model state
  // ----------
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, adc_valid = 1'b0;
  logic        fixd = 1'b0, hreadyout, hresp;
  logic [1:0]  htrans = 2'b00, sa = 2'b00, sb = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [11:0] smp_a = 12'h000, smp_b = 12'h000;
  logic [15:0] pa [4], pb [4];
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, r1, r2;
  logic [31:0] qa [$], qb [$];
  int          errors = 0, compares = 0, n;
  int          qt [16] = '{100, 300, 497, 690, 875, 1052, 1219, 1375, 1517, 1644, 1756, 1850,
                           1927, 1986, 2025, 2045};
  nco_link_if nco_link_if_i ();
  nco_mixer_dev nco_mixer_dev_i (.hclk(hclk), .hresetn(hresetn), .link(nco_link_if_i),
    .adc_sample_chan_a(smp_a), .adc_sample_chan_b(smp_b), .adc_valid(adc_valid));
  nco_host_ctrl nco_host_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(nco_link_if_i));
  nco_link_asserts nco_link_asserts_i (.hclk(hclk), .hresetn(hresetn),
    .mix_valid(nco_link_if_i.mix_valid), .mix_ready(nco_link_if_i.mix_ready),
    .mix_i_a(nco_link_if_i.mix_i_a), .mix_q_a(nco_link_if_i.mix_q_a),
    .mix_i_b(nco_link_if_i.mix_i_b), .mix_q_b(nco_link_if_i.mix_q_b),
    .overrun(nco_link_if_i.overrun), .overrun_clr(nco_link_if_i.overrun_clr),
    .resync(nco_link_if_i.resync));
  // ----------
  // model and bus tasks
  // ----------
  // table sine, half a step off zero so no entry is ever 0
  function automatic int sn(logic [5:0] p);
    int q;
    q = qt[p[4] ? ~p[3:0] : p[3:0]];
    return p[5] ? -q : q;
  endfunction
  // expected {i, q} word while the oscillator stands still
  function automatic logic [31:0] mixw(logic [11:0] x, logic [15:0] o);
    int i, q;
    i = ($signed(x) * sn(o[15:10] + 6'h10)) >>> 7;
    q = -($signed(x) * sn(o[15:10])) >>> 7;
    return {i[15:0], q[15:0]};
  endfunction
  task automatic chk(logic [31:0] g, logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one single transfer; only the watchdog ends a wait for ready
  task automatic ahb(logic w, logic [31:0] a, logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    ahb(1'b1, {24'h000000, a}, d, r);
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] q);
    ahb(1'b0, {24'h000000, a}, 32'h0, q);
  endtask
  // back-to-back samples; keep=0 leaves them out of the model
  task automatic send(int k, logic keep);
    logic [11:0] a, b;
    repeat (k) begin
      a = fixd ? 12'h080 : 12'($urandom);
      b = fixd ? 12'h080 : 12'($urandom);
      smp_a <= a;
      smp_b <= b;
      adc_valid <= 1'b1;
      if (keep) qa.push_back(mixw(a, pa[sa]));
      if (keep) qb.push_back(mixw(b, pb[sb]));
      @(posedge hclk);
    end
    adc_valid <= 1'b0;
  endtask
  task automatic drain(int k);
    repeat (k) begin
      rd(nco_pkg::ADDR_DATA_A, r);
      chk(r, qa.pop_front());
      rd(nco_pkg::ADDR_DATA_B, r);
      chk(r, qb.pop_front());
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------
  // clock, watchdog and tests
  // ----------
  always #5 hclk = ~hclk;
  // tests need about 1650 cycles; the 40000-cycle limit, some 24 times that, means a hang
  initial begin
    #400000;
    errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h456B));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int x = 0; x < 4; x++) begin
      pa[x] = 16'($urandom);
      pb[x] = 16'($urandom);
      wr({nco_pkg::REG_PHASE_A, 2'(x), 2'b00}, {16'h0000, pa[x]});
      wr({nco_pkg::REG_PHASE_B, 2'(x), 2'b00}, {16'h0000, pb[x]});
    end
    send(1, 1'b1);
    // the cycle in which the sample stood counts as the first
    n = 1;
    do begin
      @(posedge hclk);
      n++;
      #1;
    end while (nco_link_if_i.mix_valid !== 1'b1 && n < 60);
    chk(32'(n), 32'(nco_pkg::SAMPLE_LAT));
    repeat (3) @(posedge hclk);
    drain(1);
    // every index by field, then by pins, the unused source set wrong
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        sa = 2'(s);
        sb = 2'(3 - s);
        wr(nco_pkg::ADDR_PINS, m ? {28'h0, sb, sa} : {28'h0, ~sb, ~sa});
        wr(nco_pkg::ADDR_CTRL, m ? {27'h0, ~sb, ~sa, 1'b1} : {27'h0, sb, sa, 1'b0});
        repeat (45) @(posedge hclk);
        send(3, 1'b1);
        repeat (45) @(posedge hclk);
        drain(3);
      end
    end
    // fill until refused, lose one sample, then drain to empty
    send(17, 1'b1);
    repeat (50) @(posedge hclk);
    rd(nco_pkg::ADDR_STATUS, r);
    chk(r & 32'h7, 32'h2);
    chk({31'h0, nco_link_if_i.mix_ready}, 32'h0);
    send(1, 1'b0);
    repeat (3) @(posedge hclk);
    rd(nco_pkg::ADDR_STATUS, r);
    chk(r & 32'h7, 32'h6);
    drain(16);
    repeat (5) @(posedge hclk);
    drain(1);
    rd(nco_pkg::ADDR_DATA_A, r);
    chk(r, 32'h0);
    wr(nco_pkg::ADDR_CTRL, {25'h0, 1'b1, 1'b0, ~sb, ~sa, 1'b1});
    repeat (4) @(posedge hclk);
    rd(nco_pkg::ADDR_STATUS, r);
    chk(r & 32'h7, 32'h1);
    wr(nco_pkg::ADDR_RDIV, 32'h00002001);
    repeat (3) @(posedge hclk);
    rd(nco_pkg::ADDR_STATUS, r);
    chk(r & 32'h8, 32'h8);
    ahb(1'b0, 32'h00000100, 32'h0, r);
    chk(r, 32'h0);
    // half a turn per 64 cycles: plain mode negates, divider 1 restarts
    fixd = 1'b1;
    wr({nco_pkg::REG_FREQ_A, sa, 2'b00}, 32'h02000000);
    wr({nco_pkg::REG_FREQ_B, sb, 2'b00}, 32'h02000000);
    for (int d = 0; d < 2; d++) begin
      wr(nco_pkg::ADDR_RDIV, 32'(d));
      repeat (70) @(posedge hclk);
      send(1, 1'b0);
      repeat (63) @(posedge hclk);
      send(1, 1'b0);
      repeat (50) @(posedge hclk);
      rd(nco_pkg::ADDR_DATA_A, r1);
      rd(nco_pkg::ADDR_DATA_B, r);
      rd(nco_pkg::ADDR_DATA_A, r2);
      rd(nco_pkg::ADDR_DATA_B, r);
      chk(r2, d ? r1 : {-r1[31:16], -r1[15:0]});
    end
    // resync zeroes the accumulators; 128 cycles on, a whole turn has passed
    // and the mixer sees only the phase offset again
    wr(nco_pkg::ADDR_RDIV, 32'h0);
    wr(nco_pkg::ADDR_CTRL, {25'h0, 2'b01, ~sb, ~sa, 1'b1});
    repeat (94) @(posedge hclk);
    send(1, 1'b1);
    repeat (40) @(posedge hclk);
    drain(1);
    wrap_up();
  end
endmodule // quad_nco_complex_mixer_tb
`default_nettype wire
